/* bus_master_regs.svh */
// named pin levels and mode codes for the bus master block
// assumes inclusion by bare name from the gate and bus master design files
`ifndef BUS_MASTER_REGS_SVH
`define BUS_MASTER_REGS_SVH
`define PIN_HIGH 1'b1
`define PIN_LOW 1'b0
`define DIR_READ 1'b1
`define DIR_WRITE 1'b0
`define STYLE_WIDE 1'b1
`define IRQ_SRC_COUNT 16
`endif

/* bus_master_pkg.sv */
// types shared by the bus master files
// assumes the constants header is compiled alongside
package bus_master_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_REQ = 7'h02,
    ST_OWN = 7'h04,
    ST_ADDR = 7'h08,
    ST_STRB = 7'h10,
    ST_TERM = 7'h20,
    ST_REL = 7'h40
  } master_state_e;
endpackage

/* irq_if.sv */
// carrier between the bus master top and its interrupt gate
// assumes one clock domain; the top drives status and mask
`timescale 1ns/1ps
interface irq_if #(parameter int N = 16);
  logic [N-1:0] status;
  logic [N-1:0] mask;
  logic line_q;
  modport gate (input status, input mask, output line_q);
  modport user (output status, output mask, input line_q);
endinterface

/* irq_gate.sv */
// interrupt gate: registered or-reduction of pending and enabled sources
// assumes synchronous status and mask inputs
`timescale 1ns/1ps
`include "bus_master_regs.svh"
module irq_gate (
  input wire logic mclk,
  input wire logic rst_n,
  irq_if.gate irq
);
  logic line_d;

  always_comb begin
    line_d = |(irq.status & irq.mask);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq.line_q <= `PIN_LOW;
    end else begin
      irq.line_q <= line_d;
    end
  end

  irq_pending_a: assert property (@(posedge mclk) disable iff (!rst_n)
    |(irq.status & irq.mask) |=> irq.line_q)
    else $error("enabled pending source did not raise interrupt");
  irq_masked_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ((irq.status & irq.mask) == '0) |=> !irq.line_q)
    else $error("masked source raised interrupt");
endmodule

/* bus_master.sv */
// bus master acquire sequence, memory cycle strobes and interrupt pin
// assumes all pin inputs synchronous to mclk; pads resolve output enables
`timescale 1ns/1ps
`include "bus_master_regs.svh"
module bus_master #(
  parameter int IRQ_N = `IRQ_SRC_COUNT
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cycle_req,
  input wire logic cycle_write,
  output logic cycle_done,
  output logic bus_owned,
  input wire logic bus_style_select,
  input wire logic [IRQ_N-1:0] irq_status,
  input wire logic [IRQ_N-1:0] irq_mask,
  output logic interrupt_o,
  output logic interrupt_oe,
  output logic bus_request_out_o,
  output logic bus_request_out_oe,
  input wire logic bus_grant_in_n,
  input wire logic grant_acknowledge_i,
  output logic grant_acknowledge_o,
  output logic grant_acknowledge_oe,
  input wire logic address_strobe_i,
  output logic address_strobe_o,
  output logic address_strobe_oe,
  output logic memory_direction_o,
  output logic memory_direction_oe,
  input wire logic data_size_ack_low_n,
  input wire logic data_size_ack_high_n
);
  bus_master_pkg::master_state_e state_q, state_d;
  logic req_oe_q, req_oe_d;
  logic ack_oe_q, ack_oe_d;
  logic strobe_q, strobe_d;
  logic strobe_oe_q, strobe_oe_d;
  logic dir_q, dir_d;
  logic dir_oe_q, dir_oe_d;
  logic done_q, done_d;
  logic int_out_q;
  logic bus_free;
  logic cycle_end;

  irq_if #(.N(IRQ_N)) irq ();

  assign irq.status = irq_status;
  assign irq.mask = irq_mask;

  irq_gate u_irq_gate (
    .mclk(mclk),
    .rst_n(rst_n),
    .irq(irq)
  );

  // open collector: drive low while any enabled source pends
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_out_q <= `PIN_LOW;
    end else begin
      int_out_q <= `PIN_LOW;
    end
  end

  assign interrupt_o = int_out_q;
  assign interrupt_oe = irq.line_q;

  // ownership may be taken only when grant seen and previous parties are gone
  always_comb begin
    bus_free = (bus_grant_in_n == `PIN_LOW)
      && (address_strobe_i == `PIN_HIGH)
      && (data_size_ack_low_n == `PIN_HIGH)
      && (data_size_ack_high_n == `PIN_HIGH)
      && (grant_acknowledge_i == `PIN_HIGH);
  end

  // wide bus needs both acks, narrow bus only the upper one
  always_comb begin
    if (bus_style_select == `STYLE_WIDE) begin
      cycle_end = (data_size_ack_low_n == `PIN_LOW) && (data_size_ack_high_n == `PIN_LOW);
    end else begin
      cycle_end = (data_size_ack_high_n == `PIN_LOW);
    end
  end

  always_comb begin
    state_d = state_q;
    req_oe_d = req_oe_q;
    ack_oe_d = ack_oe_q;
    strobe_d = strobe_q;
    strobe_oe_d = strobe_oe_q;
    dir_d = dir_q;
    dir_oe_d = dir_oe_q;
    done_d = 1'b0;
    case (state_q)
      bus_master_pkg::ST_IDLE: begin
        if (cycle_req) begin
          req_oe_d = 1'b1;
          state_d = bus_master_pkg::ST_REQ;
        end
      end
      bus_master_pkg::ST_REQ: begin
        if (bus_free) begin
          req_oe_d = 1'b0;
          ack_oe_d = 1'b1;
          strobe_d = `PIN_HIGH;
          strobe_oe_d = 1'b1;
          state_d = bus_master_pkg::ST_OWN;
        end
      end
      bus_master_pkg::ST_OWN: begin
        dir_d = cycle_write ? `DIR_WRITE : `DIR_READ;
        dir_oe_d = 1'b1;
        state_d = bus_master_pkg::ST_ADDR;
      end
      bus_master_pkg::ST_ADDR: begin
        strobe_d = `PIN_LOW;
        state_d = bus_master_pkg::ST_STRB;
      end
      bus_master_pkg::ST_STRB: begin
        if (cycle_end) begin
          strobe_d = `PIN_HIGH;
          done_d = 1'b1;
          state_d = bus_master_pkg::ST_TERM;
        end
      end
      bus_master_pkg::ST_TERM: begin
        if (cycle_req) begin
          dir_d = cycle_write ? `DIR_WRITE : `DIR_READ;
          state_d = bus_master_pkg::ST_ADDR;
        end else begin
          ack_oe_d = 1'b0;
          strobe_oe_d = 1'b0;
          dir_oe_d = 1'b0;
          state_d = bus_master_pkg::ST_REL;
        end
      end
      bus_master_pkg::ST_REL: begin
        state_d = bus_master_pkg::ST_IDLE;
      end
      default: begin
        req_oe_d = 1'b0;
        ack_oe_d = 1'b0;
        strobe_oe_d = 1'b0;
        dir_oe_d = 1'b0;
        state_d = bus_master_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= bus_master_pkg::ST_IDLE;
      req_oe_q <= 1'b0;
      ack_oe_q <= 1'b0;
      strobe_q <= `PIN_HIGH;
      strobe_oe_q <= 1'b0;
      dir_q <= `DIR_READ;
      dir_oe_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_oe_q <= req_oe_d;
      ack_oe_q <= ack_oe_d;
      strobe_q <= strobe_d;
      strobe_oe_q <= strobe_oe_d;
      dir_q <= dir_d;
      dir_oe_q <= dir_oe_d;
      done_q <= done_d;
    end
  end

  // request and acknowledge are open-collector style: level fixed low, enable carries the state
  assign bus_request_out_o = int_out_q;
  assign bus_request_out_oe = req_oe_q;
  assign grant_acknowledge_o = int_out_q;
  assign grant_acknowledge_oe = ack_oe_q;
  assign address_strobe_o = strobe_q;
  assign address_strobe_oe = strobe_oe_q;
  assign memory_direction_o = dir_q;
  assign memory_direction_oe = dir_oe_q;
  assign cycle_done = done_q;
  assign bus_owned = ack_oe_q;

  strobe_fall_valid_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(address_strobe_o) |-> address_strobe_oe && memory_direction_oe && $past(memory_direction_oe))
    else $error("strobe fell before direction was valid");
  strobe_rise_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == bus_master_pkg::ST_STRB) && cycle_end |=> address_strobe_o && cycle_done)
    else $error("strobe did not rise at cycle end");
  dir_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == bus_master_pkg::ST_OWN) |=> (memory_direction_o == !$past(cycle_write)))
    else $error("direction level wrong for transfer");
  request_on_need_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == bus_master_pkg::ST_IDLE) && cycle_req |=> bus_request_out_oe && !bus_request_out_o)
    else $error("request not pulled low when bus needed");
  request_idle_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == bus_master_pkg::ST_IDLE) |-> !bus_request_out_oe)
    else $error("request driven while idle");
  ack_needs_free_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(grant_acknowledge_oe) |-> $past(bus_free) && $past(bus_grant_in_n == `PIN_LOW))
    else $error("acknowledge taken without grant and free bus");
  wide_term_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == bus_master_pkg::ST_STRB) && (data_size_ack_high_n == `PIN_HIGH) |=> !cycle_done)
    else $error("cycle ended without upper ack");
  release_request_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(grant_acknowledge_oe) |-> !bus_request_out_oe ##1 grant_acknowledge_oe [*2])
    else $error("request kept after acknowledge");
  not_owner_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !grant_acknowledge_oe |-> !address_strobe_oe && !memory_direction_oe)
    else $error("strobes driven without ownership");
endmodule

/* arb_model.sv */
// far side model: arbiter granting on request, slave acking strobes
// assumes the bench resolves released pins with pull-ups
`timescale 1ns/1ps
module arb_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic busy,
  input wire logic [1:0] sel,
  input wire logic [1:0] dly,
  input wire logic req_w,
  input wire logic as_w,
  output logic gnt_n,
  output logic ack0_n,
  output logic ack1_n
);
  logic [1:0] cnt;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gnt_n <= 1'b1;
      cnt <= 2'h0;
      {ack1_n, ack0_n} <= 2'h3;
    end else begin
      gnt_n <= req_w | hold;
      cnt <= as_w ? 2'h0 : (cnt == dly ? cnt : cnt + 2'h1);
      // acks released while strobe is high; busy mimics a slave still on the bus
      {ack1_n, ack0_n} <= busy ? 2'h0 : ((!as_w && cnt == dly) ? ~sel : 2'h3);
    end
  end
endmodule

/* tb.sv */
// bench for bus_master with arbiter and slave model on its pins
// assumes pull-ups on every released pin
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0, rst_n = 1'b0, cycle_req = 1'b0, cycle_write = 1'b0, style = 1'b1, hold = 1'b0, busy = 1'b0;
  logic other_as = 1'b1, other_ack = 1'b1, exp_dir = 1'b1, got = 1'b0, as_prev = 1'b1;
  logic [1:0] sel = 2'h3, dly = 2'h0;
  logic [15:0] st = 16'h0, mk = 16'h0;
  logic done, owned, int_o, int_oe, br_o, br_oe, gnt_n, ga_o, ga_oe, as_o, as_oe, dir_o, dir_oe, ack0_n, ack1_n;
  wire req_w = br_oe ? br_o : 1'b1;
  wire as_w = as_oe ? as_o : other_as;
  wire ga_w = ga_oe ? ga_o : other_ack;
  int fail_count = 0, n_compared = 0;
  bus_master uut (.mclk(mclk), .rst_n(rst_n), .cycle_req(cycle_req), .cycle_write(cycle_write),
    .cycle_done(done), .bus_owned(owned), .bus_style_select(style), .irq_status(st), .irq_mask(mk),
    .interrupt_o(int_o), .interrupt_oe(int_oe), .bus_request_out_o(br_o), .bus_request_out_oe(br_oe),
    .bus_grant_in_n(gnt_n), .grant_acknowledge_i(ga_w), .grant_acknowledge_o(ga_o),
    .grant_acknowledge_oe(ga_oe), .address_strobe_i(as_w), .address_strobe_o(as_o),
    .address_strobe_oe(as_oe), .memory_direction_o(dir_o), .memory_direction_oe(dir_oe),
    .data_size_ack_low_n(ack0_n), .data_size_ack_high_n(ack1_n));
  arb_model far (.mclk(mclk), .rst_n(rst_n), .hold(hold), .busy(busy), .sel(sel), .dly(dly), .req_w(req_w),
    .as_w(as_w), .gnt_n(gnt_n), .ack0_n(ack0_n), .ack1_n(ack1_n));
  initial forever #10 mclk = ~mclk;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // one memory cycle; keep leaves the request up for a follow-on cycle
  task automatic do_cycle(input logic wr, input logic keep, input int lim);
    cycle_write = wr;
    exp_dir = ~wr;
    cycle_req = 1'b1;
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(negedge mclk);
      got = done;
    end
    if (got && !keep) cycle_req = 1'b0;
  endtask
  always @(negedge mclk) begin
    if (as_prev && !as_w && as_oe) begin
      check("dir", {dir_oe, dir_o}, {1'b1, exp_dir});
      check("ack held", {ga_oe, ga_o}, 2'b10);
      check("req off", br_oe, 1'b0);
    end
    as_prev <= as_w;
  end
  task automatic irq_case(input logic [15:0] s, input logic [15:0] m, input logic e);
    st = s;
    mk = m;
    ticks(2);
    check("irq", {int_oe, int_o}, {e, 1'b0});
  endtask
  task automatic t_read();
    check("idle", {br_oe, as_oe, dir_oe, ga_oe}, 4'h0);
    hold = 1'b1;
    cycle_req = 1'b1;
    ticks(4);
    check("req", {br_oe, br_o, ga_oe}, 3'b100);
    hold = 1'b0;
    do_cycle(1'b0, 1'b0, 20);
    check("read", got, 1'b1);
    ticks(3);
    check("free", {br_oe, ga_oe, as_oe, dir_oe, owned}, 5'h0);
  endtask
  // each check sees one blocker; the next is raised before the previous drops
  task automatic t_block();
    sel = 2'h0;
    other_as = 1'b0;
    cycle_req = 1'b1;
    ticks(6);
    check("busy as", ga_oe, 1'b0);
    busy = 1'b1;
    ticks(2);
    other_as = 1'b1;
    ticks(4);
    check("busy size ack", ga_oe, 1'b0);
    other_ack = 1'b0;
    ticks(2);
    busy = 1'b0;
    ticks(4);
    check("busy ack", ga_oe, 1'b0);
    other_ack = 1'b1;
    sel = 2'h3;
    do_cycle(1'b1, 1'b0, 20);
    check("write", got, 1'b1);
    ticks(3);
  endtask
  task automatic t_width();
    sel = 2'h1;
    do_cycle(1'b0, 1'b0, 12);
    check("half ack", got, 1'b0);
    sel = 2'h3;
    do_cycle(1'b0, 1'b0, 20);
    check("full ack", got, 1'b1);
    ticks(3);
    style = 1'b0;
    sel = 2'h2;
    do_cycle(1'b0, 1'b0, 20);
    check("narrow", got, 1'b1);
    ticks(3);
  endtask
  task automatic t_b2b();
    style = 1'b1;
    sel = 2'h3;
    dly = 2'h3;
    do_cycle(1'b1, 1'b1, 20);
    check("first", got, 1'b1);
    do_cycle(1'b0, 1'b0, 20);
    check("second", {got, owned}, 2'h3);
    ticks(3);
    check("gone", {ga_oe, as_oe}, 2'h0);
  endtask
  initial begin
    ticks(12);
    rst_n = 1'b1;
    ticks(2);
    irq_case(16'h8000, 16'h7fff, 1'b0);
    irq_case(16'h8000, 16'h8000, 1'b1);
    irq_case(16'h0000, 16'hffff, 1'b0);
    t_read();
    t_block();
    t_width();
    t_b2b();
    finish_test();
  end
  initial begin
    #20000;
    fail_count++;
    finish_test();
  end
endmodule
